// ===== bbar_pkg.sv
// Summary of operation
// RULE1: each region has a 32 MB alias window, one word per bit of its 1 MB.
// RULE2: alias accesses reach memory with the same size as issued.
// RULE3: direct SRAM bit-band accesses pass through as plain SRAM accesses.
// RULE4: SRAM alias data accesses remap; instruction fetches there pass unchanged.
// RULE5: direct peripheral bit-band accesses pass through as plain accesses.
// RULE6: peripheral alias data accesses remap; instruction fetches there fault.
// RULE7: alias writes are read, modify one bit, then write back.
// RULE8: alias address is base plus 32 times byte index plus 4 times bit.
// RULE9: bit index within the byte runs 0 to 7.
// RULE10: alias write sets target bit if data bit 0 is one, else clears.
// RULE11: written data bits 31 to 1 are ignored.
// RULE12: alias read returns 0 or 1 by the target bit.
// RULE13: words are stored little-endian, low byte at low address.
// RULE14: load-exclusive returns data and sets the exclusive tag; alias data accesses here set no tag.
// RULE15: store-exclusive reports status; clear means written, set means not.
// RULE16: exclusive pairs work at word, halfword and byte sizes.
// RULE17: drop-exclusive-tag command clears the tag.
// RULE18: every store-exclusive clears the tag, pass or fail; alias data stores here leave the tag as it was.
// RULE19: a taken exception clears the tag.
// RULE20: master pairs each exclusive load with same-size store, same place.
// RULE21: on failure the master retries the full exclusive sequence.
// RULE22: store-exclusive without a tag fails and leaves memory unchanged; alias data stores here still write and report success.
// RULE23: alias read and write-back run as one locked memory sequence.
package bbar_pkg;
  localparam logic [31:0] SRAM_BB_BASE = 32'h2000_0000;
  localparam logic [31:0] PERI_BB_BASE = 32'h4000_0000;
  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
  localparam int ALIAS_SPAN_BITS = 25;
  localparam int BB_SPAN_BITS = 20;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [31:0] ALIAS_ONE = 32'h0000_0001;
  localparam logic [31:0] ALIAS_ZERO = 32'h0000_0000;
  typedef enum logic [2:0] {
    BBAR_IDLE, BBAR_PASS, BBAR_RD, BBAR_WR, BBAR_RESP
  } bbar_state_t;
endpackage

// ===== bbar_excl_mon.sv
`timescale 1ns/1ps
module bbar_excl_mon
  import bbar_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // events
  input wire logic set_tag,
  input wire logic [31:0] set_addr,
  input wire logic [1:0] set_size,
  input wire logic drop,
  input wire logic [31:0] chk_addr,
  input wire logic [1:0] chk_size,
  // result
  output logic chk_ok,
  output logic tag_valid
);
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [1:0] size;
  } bbar_mon_t;
  bbar_mon_t s_q, s_d;

  // a tag only matches the very same address and size
  assign chk_ok = s_q.valid && s_q.addr == chk_addr && s_q.size == chk_size;
  assign tag_valid = s_q.valid;

  always_comb begin
    s_d = s_q;
    if (drop) begin
      s_d.valid = 1'b0; // RULE17
    end
    if (set_tag) begin
      s_d.valid = 1'b1; // RULE14
      s_d.addr = set_addr;
      s_d.size = set_size; // RULE16
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ===== bbar_remap.sv
`timescale 1ns/1ps
module bbar_remap
  import bbar_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // processor side request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_wdata,
  input wire logic req_instr,
  input wire logic req_excl,
  // processor side events
  input wire logic drop_exclusive_tag,
  input wire logic exception_taken,
  // processor side response
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic rsp_fault,
  output logic rsp_excl_fail,
  output logic excl_tag_held,
  // memory side
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [31:0] mem_addr,
  output logic mem_write,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  output logic mem_lock,
  input wire logic mem_rvalid,
  input wire logic [31:0] mem_rdata
);
  // ******************************************************
  // state
  // ******************************************************
  // one record so the whole datapath moves on a single edge
  typedef struct packed {
    bbar_state_t st;
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic [31:0] wdata;
    logic [4:0] bitpos;
    logic newbit;
    logic excl;
    logic mem_valid;
    logic mem_lock;
    logic rsp_valid;
    logic [31:0] rdata;
    logic fault;
    logic excl_fail;
  } bbar_rm_t;
  bbar_rm_t s_q, s_d;

  logic mon_ok;
  logic mon_set;
  logic mon_drop;

  // ******************************************************
  // address decoding
  // ******************************************************
  function automatic logic in_alias(input logic [31:0] a,
                                    input logic [31:0] base);
    in_alias = a[31:ALIAS_SPAN_BITS] == base[31:ALIAS_SPAN_BITS]; // RULE1
  endfunction

  // byte index is word offset / 32, bit index is (offset / 4) & 7
  function automatic logic [31:0] bb_addr(input logic [31:0] a,
                                          input logic [31:0] base);
    logic [19:0] byte_ix;
    byte_ix = a[24:5];
    bb_addr = {base[31:BB_SPAN_BITS], byte_ix}; // RULE8
  endfunction

  // lane of the target bit, little-endian within the access width
  function automatic logic [4:0] bit_lane(input logic [31:0] a,
                                          input logic [1:0] sz);
    logic [4:0] lane;
    lane = {2'h0, a[4:2]}; // RULE9
    case (sz)
      SIZE_WORD: bit_lane = {a[6:5], 3'h0} | lane; // RULE13
      SIZE_HALF: bit_lane = {1'b0, a[5], 3'h0} | lane;
      default: bit_lane = lane;
    endcase
  endfunction

  // memory returns the addressed lanes right-aligned for its size
  function automatic logic [31:0] mem_base_addr(input logic [31:0] a,
                                                input logic [1:0] sz);
    case (sz)
      SIZE_WORD: mem_base_addr = {a[31:2], 2'h0};
      SIZE_HALF: mem_base_addr = {a[31:1], 1'b0};
      default: mem_base_addr = a;
    endcase
  endfunction

  logic is_sram_alias;
  logic is_peri_alias;
  assign is_sram_alias = in_alias(req_addr, SRAM_ALIAS_BASE);
  assign is_peri_alias = in_alias(req_addr, PERI_ALIAS_BASE);

  // ******************************************************
  // alias target
  // ******************************************************
  // the bit-band base, not the alias base, forms the memory address
  logic [31:0] bb_base;
  logic [31:0] bb_target;
  logic [31:0] alias_mem_addr;
  logic [4:0] alias_lane;
  logic is_alias_data;
  logic is_fetch_fault;
  logic excl_refused;
  logic take;
  assign take = req_valid && req_ready;
  assign bb_base = is_sram_alias ? SRAM_BB_BASE : PERI_BB_BASE;
  assign bb_target = bb_addr(req_addr, bb_base); // RULE8
  assign alias_mem_addr = mem_base_addr(bb_target, req_size); // RULE2
  // lane comes from the alias address: bits 6:5 pick the byte
  assign alias_lane = bit_lane(req_addr, req_size); // RULE9 RULE13
  // sram alias fetches fall through as plain accesses
  assign is_alias_data = !req_instr && (is_sram_alias || is_peri_alias);
  assign is_fetch_fault = req_instr && is_peri_alias; // RULE6
  // no matching tag: an exclusive store that is not alias data never reaches memory
  assign excl_refused = req_excl && req_write && !mon_ok; // RULE22

  // ******************************************************
  // write-back merge
  // ******************************************************
  // all other lanes go back exactly as read, so neighbouring bits of
  // a peripheral register keep their value
  logic [31:0] lane_hit;
  logic [31:0] merged;
  logic alias_bit;
  for (genvar i = 0; i < 32; i++) begin : g_merge
    assign lane_hit[i] = s_q.bitpos == 5'(i); // RULE9
    assign merged[i] = lane_hit[i] ? s_q.newbit : mem_rdata[i]; // RULE7
  end
  assign alias_bit = |(lane_hit & mem_rdata); // RULE12

  // ******************************************************
  // memory handshake
  // ******************************************************
  // read data may come with or after ready; writes see no rvalid
  logic mem_taken;
  logic rd_done;
  logic wr_done;
  assign mem_taken = s_q.mem_valid && mem_ready;
  assign rd_done = !s_q.write && mem_rvalid;
  assign wr_done = s_q.write && mem_ready;

  // ******************************************************
  // outputs
  // ******************************************************
  // handshake back to the processor
  assign req_ready = s_q.st == BBAR_IDLE;
  // memory request, all from flip-flops
  assign mem_valid = s_q.mem_valid;
  assign mem_addr = s_q.addr;
  assign mem_write = s_q.write;
  assign mem_size = s_q.size; // RULE2
  assign mem_wdata = s_q.wdata;
  assign mem_lock = s_q.mem_lock;

  // registered answer
  assign rsp_valid = s_q.rsp_valid;
  assign rsp_rdata = s_q.rdata;
  assign rsp_fault = s_q.fault;
  assign rsp_excl_fail = s_q.excl_fail;

  // ******************************************************
  // sequencing
  // ******************************************************
  always_comb begin
    s_d = s_q;
    s_d.rsp_valid = 1'b0;
    mon_set = 1'b0;
    mon_drop = drop_exclusive_tag || exception_taken; // RULE17 RULE19
    case (s_q.st)
      BBAR_IDLE: begin
        // write, size, excl and wdata are captured at every take
        if (take) begin
          s_d.write = req_write;
          s_d.size = req_size;
          s_d.excl = req_excl;
          s_d.wdata = req_wdata;
          s_d.fault = 1'b0;
          s_d.excl_fail = 1'b0;
          s_d.rdata = ALIAS_ZERO;
          if (is_fetch_fault) begin
            // answered at once; nothing goes to memory
            s_d.fault = 1'b1; // RULE6
            s_d.rsp_valid = 1'b1;
            s_d.st = BBAR_IDLE;
          end else if (is_alias_data) begin
            s_d.addr = alias_mem_addr; // RULE4
            s_d.bitpos = alias_lane;
            s_d.newbit = req_wdata[0]; // RULE10 RULE11
            s_d.write = 1'b0;
            s_d.mem_valid = 1'b1;
            s_d.mem_lock = req_write; // RULE23
            s_d.st = BBAR_RD;
          end else if (excl_refused) begin
            // no tag or mismatch: nothing reaches memory
            s_d.excl_fail = 1'b1; // RULE15 RULE22
            s_d.rsp_valid = 1'b1;
            mon_drop = 1'b1; // RULE18
          end else begin
            // direct bit-band and all other accesses pass unchanged
            s_d.addr = req_addr; // RULE3 RULE5
            s_d.mem_valid = 1'b1;
            s_d.mem_lock = 1'b0;
            s_d.st = BBAR_PASS;
            if (req_excl) begin
              if (req_write) begin
                mon_drop = 1'b1; // RULE18
              end else begin
                mon_set = 1'b1; // RULE14 RULE16
              end
            end
          end
        end
      end
      BBAR_PASS: begin
        // ready ends the address phase; read data may trail it
        if (mem_taken) begin
          s_d.mem_valid = 1'b0;
        end
        if (wr_done || rd_done) begin
          s_d.mem_valid = 1'b0;
          s_d.rdata = s_q.write ? ALIAS_ZERO : mem_rdata;
          s_d.rsp_valid = 1'b1;
          s_d.st = BBAR_IDLE;
        end
      end
      BBAR_RD: begin
        if (mem_taken) begin
          s_d.mem_valid = 1'b0;
        end
        if (rd_done) begin
          if (s_q.mem_lock) begin
            // write-back keeps the lock held across both halves
            s_d.wdata = merged; // RULE7 RULE10
            s_d.write = 1'b1;
            s_d.mem_valid = 1'b1;
            s_d.st = BBAR_WR;
          end else begin
            // alias read returns only the target bit
            s_d.rdata = alias_bit ? ALIAS_ONE : ALIAS_ZERO; // RULE12
            s_d.rsp_valid = 1'b1;
            s_d.st = BBAR_IDLE;
          end
        end
      end
      BBAR_WR: begin
        // lock drops with the write-back, never between read and write
        if (mem_taken) begin
          s_d.mem_valid = 1'b0;
          s_d.mem_lock = 1'b0; // RULE23
          s_d.rsp_valid = 1'b1;
          s_d.st = BBAR_IDLE;
        end
      end
      default: begin
        // unused codes return to idle
        s_d.st = BBAR_IDLE;
      end
    endcase
  end

  // ******************************************************
  // registers
  // ******************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ******************************************************
  // exclusive monitor
  // ******************************************************
  // the tag records the raw request; alias data accesses never set it
  bbar_excl_mon u_mon (
    .clk(clk),
    .rst(rst),
    .set_tag(mon_set),
    .set_addr(req_addr),
    .set_size(req_size),
    .drop(mon_drop),
    .chk_addr(req_addr),
    .chk_size(req_size),
    .chk_ok(mon_ok),
    .tag_valid(excl_tag_held)
  );
endmodule

// ===== bbar_remap_props.sv
`timescale 1ns/1ps
module bbar_remap_props
  import bbar_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // processor side
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_wdata,
  input wire logic req_instr,
  input wire logic req_excl,
  input wire logic drop_exclusive_tag,
  input wire logic exception_taken,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata,
  input wire logic rsp_fault,
  input wire logic rsp_excl_fail,
  input wire logic excl_tag_held,
  // memory side
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic mem_write,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_lock
);
  // ***
  // request capture
  // ***
  logic tk;
  logic al;
  logic ar_q;
  logic aw_q;
  logic [31:0] a_q;
  logic [31:0] w_q;
  logic [1:0] s_q;
  logic [4:0] ln;
  assign tk = req_valid && req_ready;
  assign al = !req_instr && (req_addr[31:25] == 7'h11 ||
    req_addr[31:25] == 7'h21);
  // bit lane sits inside the size-aligned memory lanes
  assign ln = {a_q[6:5] & {s_q[1], |s_q}, a_q[4:2]};
  always_ff @(posedge clk) begin
    if (tk) begin
      a_q <= req_addr;
      w_q <= req_wdata;
      s_q <= req_size;
      ar_q <= al && !req_write;
      aw_q <= al && req_write;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  alias_size_a: assert property (mem_valid |-> mem_size == s_q)
    else $error("memory size differs");
  bb_region_a: assert property (mem_valid && mem_lock |->
    (mem_addr[31:20] == 12'h200 || mem_addr[31:20] == 12'h400))
    else $error("alias left bit-band region");
  bb_byte_a: assert property (mem_valid && mem_lock |->
    mem_addr[19:2] == a_q[24:7]) else $error("wrong bit-band byte");
  wr_bit_a: assert property (mem_valid && mem_write && mem_lock |->
    mem_wdata[ln] == w_q[0]) else $error("wrong written bit");
  rd_bit_a: assert property (rsp_valid && ar_q |->
    rsp_rdata[31:1] == 31'h0) else $error("alias read not 0 or 1");
  tag_drop_a: assert property ((drop_exclusive_tag ||
    exception_taken) && !(tk && req_excl && !req_write) |=> !excl_tag_held)
    else $error("tag kept after drop");
  tag_set_a: assert property (tk && req_excl && !req_write && !al
    |=> excl_tag_held) else $error("tag not set");
  tag_clr_a: assert property (tk && req_excl && req_write && !al
    |=> !excl_tag_held) else $error("tag kept after store");
  lock_hold_a: assert property (mem_valid |-> mem_lock == aw_q)
    else $error("lock differs from alias write");
  fetch_fault_a: assert property (tk && req_instr &&
    req_addr[31:25] == 7'h21 |=> rsp_valid && rsp_fault)
    else $error("peripheral alias fetch not faulted");
  store_fail_a: assert property (tk && req_excl && req_write &&
    !req_instr && !al && !excl_tag_held |=> rsp_valid && rsp_excl_fail &&
    !mem_valid) else $error("untagged store not refused");
  cover property (mem_valid && mem_write && mem_lock);
  cover property (rsp_valid && ar_q);
  cover property (tk && req_excl && req_write && excl_tag_held);
endmodule
bind bbar_remap bbar_remap_props u_props (.*);

// ===== bbar_mem.sv
`timescale 1ns/1ps
module bbar_mem (
  // control
  input wire logic clk,
  input wire logic slow,
  // memory port
  input wire logic mem_valid,
  output logic mem_ready,
  input wire logic [31:0] mem_addr,
  input wire logic mem_write,
  input wire logic [1:0] mem_size,
  input wire logic [31:0] mem_wdata,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  // ***
  // memory model
  // ***
  logic [31:0] ram [0:63];
  logic [2:0] wait_q = 3'h0;
  logic [4:0] sh;
  logic [31:0] msk;
  logic [5:0] ix;
  assign ix = mem_addr[7:2];
  assign sh = {mem_addr[1:0] & ~{mem_size[1], |mem_size}, 3'h0};
  assign msk = mem_size[1] ? 32'hFFFF_FFFF : {16'h0, {8{mem_size[0]}}, 8'hFF};
  initial begin
    {mem_ready, mem_rvalid, mem_rdata} = '0;
    for (int i = 0; i < 64; i++) ram[i] = 32'(i) * 32'h0101_0101;
  end
  // released data bus toggles so stale values never look valid
  always @(posedge clk) begin
    mem_ready <= 1'h0;
    mem_rvalid <= 1'h0;
    mem_rdata <= ~mem_rdata;
    if (mem_valid && !mem_ready) begin
      wait_q <= wait_q + 3'h1;
      if (wait_q >= (slow ? 3'h3 : 3'h0)) begin
        wait_q <= 3'h0;
        mem_ready <= 1'h1;
        if (mem_write) begin
          ram[ix] <= (ram[ix] & ~(msk << sh)) | ((mem_wdata & msk) << sh);
        end else begin
          mem_rvalid <= 1'h1;
          mem_rdata <= (ram[ix] >> sh) & msk;
        end
      end
    end
  end
endmodule

// ===== bbar_remap_tb.sv
`timescale 1ns/1ps
module bbar_remap_tb
  import bbar_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic req_valid, req_write, req_instr, req_excl, slow, req_ready;
  logic drop_exclusive_tag, exception_taken, rsp_valid, rsp_fault;
  logic rsp_excl_fail, excl_tag_held, mem_valid, mem_ready, mem_write;
  logic mem_lock, mem_rvalid;
  logic [1:0] req_size, mem_size;
  logic [31:0] req_addr, req_wdata, rsp_rdata, mem_addr, mem_wdata;
  logic [31:0] mem_rdata, got;
  int error_cnt = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  bbar_remap DUT (.*);
  bbar_mem part (.*);
  // ***
  // helpers
  // ***
  task end_sim;
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input logic [31:0] a, input logic [1:0] s = SIZE_WORD,
    input logic w = 1'h0, input logic [31:0] d = 32'h0,
    input logic i = 1'h0, input logic x = 1'h0);
    int n;
    {req_addr, req_size, req_write, req_wdata} = {a, s, w, d};
    {req_instr, req_excl, req_valid} = {i, x, 1'h1};
    n = 0;
    while (req_ready !== 1'h1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 req_valid = 1'h0;
    while (rsp_valid !== 1'h1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    got = rsp_rdata;
    // one idle edge so back-to-back calls never re-raise valid at once
    @(posedge clk);
    #1;
    if (n >= 60) begin
      error_cnt++;
      $display("mismatch t=%0t no response", $time);
      end_sim;
    end
  endtask
  task t_direct;
    acc(32'h2000_0004, SIZE_WORD, 1'h1, 32'h4433_2211);
    acc(32'h2000_0005, SIZE_BYTE);
    chk(got, 32'h22);
    acc(32'h4000_0006, SIZE_HALF);
    chk(got, 32'h4433);
  endtask
  task t_alias;
    for (int b = 0; b < 8; b++) begin
      acc(SRAM_ALIAS_BASE + 32'hA0 + 32'(b * 4));
      chk(got, 32'((8'h22 >> b) & 8'h01));
    end
    acc(SRAM_ALIAS_BASE + 32'h80, SIZE_BYTE, 1'h1, 32'hFFFF_FFFE);
    acc(PERI_ALIAS_BASE + 32'h9C, SIZE_HALF, 1'h1, 32'h1);
    chk(part.ram[1], 32'h4433_2290);
  endtask
  task t_fetch;
    acc(PERI_ALIAS_BASE, SIZE_WORD, 1'h0, 32'h0, 1'h1);
    chk({31'h0, rsp_fault}, 32'h1);
    acc(SRAM_ALIAS_BASE + 32'h4, SIZE_WORD, 1'h0, 32'h0, 1'h1);
    chk(got, 32'h4433_2290);
    chk({31'h0, rsp_fault}, 32'h0);
  endtask
  task t_excl;
    for (int s = 0; s < 3; s++) begin
      acc(32'h2000_0008, 2'(s), 1'h0, 32'h0, 1'h0, 1'h1);
      chk({31'h0, excl_tag_held}, 32'h1);
      acc(32'h2000_0008, 2'(s), 1'h1, 32'h5A5A_5A5A, 1'h0, 1'h1);
      chk({31'h0, rsp_excl_fail}, 32'h0);
      acc(32'h2000_0008, 2'(s), 1'h1, 32'hFFFF_FFFF, 1'h0, 1'h1);
      chk({31'h0, rsp_excl_fail}, 32'h1);
    end
    chk(part.ram[2], 32'h5A5A_5A5A);
  endtask
  task t_clear;
    for (int k = 0; k < 2; k++) begin
      acc(32'h2000_000C, SIZE_WORD, 1'h0, 32'h0, 1'h0, 1'h1);
      {drop_exclusive_tag, exception_taken} = k[0] ? 2'h1 : 2'h2;
      @(posedge clk);
      #1 {drop_exclusive_tag, exception_taken} = 2'h0;
      acc(32'h2000_000C, SIZE_WORD, 1'h1, 32'h0, 1'h0, 1'h1);
      chk({31'h0, rsp_excl_fail}, 32'h1);
      acc(32'h2000_000C, SIZE_WORD, 1'h0, 32'h0, 1'h0, 1'h1);
      acc(32'h2000_000C, SIZE_WORD, 1'h1, 32'(k) + 32'h7, 1'h0, 1'h1);
      chk(part.ram[3], 32'(k) + 32'h7);
    end
  endtask
  initial begin
    {req_valid, req_write, req_instr, req_excl, slow} = '0;
    {drop_exclusive_tag, exception_taken, req_size} = '0;
    {req_addr, req_wdata} = '0;
    repeat (2) @(posedge clk);
    #1 rst = 1'h0;
    t_direct;
    slow = 1'h1;
    t_alias;
    slow = 1'h0;
    t_fetch;
    t_excl;
    t_clear;
    end_sim;
  end
endmodule
